// *** rtl/boost_sync_and_dimming_control.sv ***
// Sequencer for soft start, oscillator selection, sync fallback and PWM dimming
//
// Functional notes
// R1: During soft start sinks use reduced current and switch limit is reduced.
// R2: Enough sink voltage ramps sinks to full current and full switch limit.
// R3: Internal oscillator period follows resistor setting, 200 kHz to 2.3 MHz.
// R4: Switching rate clamped so it never exceeds 3.5 MHz.
// R5: Stay off while sync pin low; start when pin floats high or clocks.
// R6: Detected external clock becomes switching clock without disturbing sink current.
// R7: Host keeps sync pulses high and low at least 150 ns each.
// R8: Lost sync falls back to resistor frequency, pausing at most about 7 us.
// R9: Sync pin low over 7 us shuts down: no switching, disconnect open, sinks off.
// R10: After stuck-low shutdown, released sync pin restarts through soft start.
// R11: Dimming pin low for 32,750 switching cycles enters low power.
// R12: Host switches oscillator source only 500 ns after dim rise or while low.
// R13: Dimming pin high turns device on, enabled sinks at full current.
// R14: Dimming pin low stops boost and sinks, floats compensation, core stays alive.
// R15: Dimming edges reach sink current well within 500 ns.
// R16: Sink status evaluated 3000 to 4000 switching cycles after threshold crossing.
// R17: Internal counters time sync-low and dim-low, cleared by edges.
`timescale 1ns/10ps
`default_nettype none
module boost_sync_and_dimming_control (
   input  wire logic                              mclk,
   input  wire logic                              rstn,
   input  wire logic                              sync_clk,
   input  wire logic                              freq_set_sync_pin,
   input  wire logic                              dim_en_pin,
   input  wire logic                              sink_ok,
   input  wire logic                              sink_short,
   input  wire logic [boost_ctrl_pkg::PER_W-1:0]  rset_period,
   output logic                                   sw_clk_en,
   output logic                                   sw_pulse,
   output logic                                   ilim_full,
   output logic [1:0]                             sink_level,
   output logic                                   disconnect_on,
   output logic                                   comp_float,
   output logic                                   low_power,
   output logic                                   ext_sync_active
);
   import boost_ctrl_pkg::*;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [1:0] pin_s_r;
   logic [1:0] dim_s_r;
   logic [1:0] ok_s_r;
   logic [1:0] sh_s_r;
   logic [2:0] tgl_s_r;
   logic       edge_tgl;

   sync_edge_detect u_sync_edge (
      .sync_clk (sync_clk),
      .rstn     (rstn),
      .edge_tgl (edge_tgl)
   );

   // Two flops per asynchronous input; third toggle stage only for edge detect
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_s_r <= 2'h0;
         dim_s_r <= 2'h0;
         ok_s_r  <= 2'h0;
         sh_s_r  <= 2'h0;
         tgl_s_r <= 3'h0;
      end else begin
         pin_s_r <= {pin_s_r[0], freq_set_sync_pin};
         dim_s_r <= {dim_s_r[0], dim_en_pin};
         ok_s_r  <= {ok_s_r[0], sink_ok};
         sh_s_r  <= {sh_s_r[0], sink_short};
         tgl_s_r <= {tgl_s_r[1:0], edge_tgl};
      end
   end

   wire pin_hi    = pin_s_r[1];
   wire dim_hi    = dim_s_r[1];
   wire snk_ok    = ok_s_r[1];
   wire snk_short = sh_s_r[1];
   wire sync_edge = tgl_s_r[2] ^ tgl_s_r[1];

   // ****************************************************************
   // Sync pin timers
   // ****************************************************************
   logic [TMR_W-1:0] low_tmr_r;
   logic [TMR_W-1:0] since_edge_r;
   logic             ext_r;
   logic             pause_r;
   logic             dim_d_r;

   // Both timers restart on every detected sync edge [R17]
   wire low_timeout  = (low_tmr_r >= TMR_W'(SYNC_LOW_CYC));   // [R9]
   wire edge_timeout = (since_edge_r >= TMR_W'(SYNC_LOSS_CYC));
   wire dim_rise     = dim_hi & ~dim_d_r;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         low_tmr_r    <= '0;
         since_edge_r <= '0;
      end else begin
         low_tmr_r    <= (pin_hi | sync_edge) ? '0 : (low_timeout ? low_tmr_r : low_tmr_r + 1'b1);    // [R17]
         since_edge_r <= sync_edge ? '0 : (edge_timeout ? since_edge_r : since_edge_r + 1'b1);
      end
   end

   // Sync edge selects external clock; lost edges pause then revert [R6] [R8]
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ext_r   <= 1'b0;
         pause_r <= 1'b0;
         dim_d_r <= 1'b0;
      end else begin
         dim_d_r <= dim_hi;
         if (sync_edge) begin
            ext_r   <= 1'b1;                                   // [R6]
            pause_r <= 1'b0;
         end else if (ext_r && since_edge_r == TMR_W'(SYNC_LOSS_CYC / 2)) begin
            pause_r <= 1'b1;                                   // [R8]
         end else if (edge_timeout) begin
            ext_r   <= 1'b0;                                   // [R8]
            pause_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Switching clock generation
   // ****************************************************************
   logic [PER_W-1:0] osc_cnt_r;
   logic             sw_tick_r;
   logic             ext_tick_r;

   // Resistor-set period, bounded to the supported band and the fault clamp
   wire [PER_W-1:0] per_clamp = (rset_period < PER_W'(CLAMP_PER_CYC)) ? PER_W'(CLAMP_PER_CYC) :      // [R4]
                                (rset_period > PER_W'(RSET_MAX_PER_CYC)) ? PER_W'(RSET_MAX_PER_CYC) :
                                rset_period;                                                         // [R3]
   wire osc_wrap = (osc_cnt_r >= per_clamp - 1'b1);
   // In external mode the counter measures the gap since the last sync edge.
   // Restarting it at the resistor wrap would make every sync edge look too early.
   // The loss timeout drops the external select long before this counter can wrap.
   wire osc_clr  = ext_r ? sync_edge : osc_wrap;
   // External edges closer than the clamp period are dropped [R4]
   wire ext_ok   = sync_edge & (osc_cnt_r >= PER_W'(CLAMP_PER_CYC - 1));
   wire tick_nxt = ext_r ? ext_ok : osc_wrap;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         osc_cnt_r <= '0;
         sw_tick_r <= 1'b0;
      end else begin
         osc_cnt_r <= osc_clr ? '0 : osc_cnt_r + 1'b1;
         sw_tick_r <= tick_nxt;
      end
   end

   // Registers external edges that are kept, so the tick lines up with the source
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ext_tick_r <= 1'b0;
      end else begin
         ext_tick_r <= ext_r & ext_ok;
      end
   end

   // ****************************************************************
   // State decode
   // ****************************************************************
   // States in which the sinks may conduct once the dimming pin is high
   function automatic logic leds_allowed(input seq_state_e s);
      leds_allowed = (s == ST_SOFT) || (s == ST_RUN);
   endfunction : leds_allowed

   // States that keep the input disconnect switch closed
   function automatic logic supply_on(input seq_state_e s);
      supply_on = (s == ST_DETECT) || (s == ST_SOFT) || (s == ST_RUN);
   endfunction : supply_on

   // Only the regulation state gets full sink current and full switch limit
   function automatic logic at_full(input seq_state_e s);
      at_full = (s == ST_RUN);
   endfunction : at_full

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   seq_state_e        st_r;
   seq_state_e        st_nxt;
   logic [SWC_W-1:0]  swc_r;
   logic [SWC_W-1:0]  dimlo_r;

   wire detect_done = (swc_r >= SWC_W'(DETECT_MIN_SW_CYC));                  // [R16]
   wire lowpwr_hit  = (dimlo_r >= SWC_W'(LOWPWR_SW_CYC));                    // [R11]
   wire start_ok    = pin_hi | ext_r;                                        // [R5]

   // Power-up waits on the sync pin, stuck-low forces shutdown from any active state.
   // A stale external-select flag must not end a stuck-low shutdown: the select drops
   // no later than the pin-low timeout, and only a fresh level or edge counts.
   // Leaving the shutdown skips detection, even when the shutdown cut ST_DETECT short.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_WAIT_PIN: if (start_ok && dim_hi)              st_nxt = ST_DETECT;   // [R5]
         ST_DETECT:   if (low_timeout)                     st_nxt = ST_STUCK;
                      else if (detect_done && !snk_short)  st_nxt = ST_SOFT;     // [R16]
         ST_SOFT:     if (low_timeout)                     st_nxt = ST_STUCK;
                      else if (snk_ok)                     st_nxt = ST_RUN;      // [R2]
         ST_RUN:      if (low_timeout)                     st_nxt = ST_STUCK;    // [R9]
                      else if (lowpwr_hit)                 st_nxt = ST_LOWPWR;   // [R11]
         ST_STUCK:    if (pin_hi || sync_edge)             st_nxt = ST_SOFT;     // [R10]
         ST_LOWPWR:   if (dim_rise)                        st_nxt = ST_WAIT_PIN;
      endcase
   end

   // Detection counter counts switching ticks; dim-low counter clears on a rising edge [R17]
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r    <= ST_WAIT_PIN;
         swc_r   <= '0;
         dimlo_r <= '0;
      end else begin
         st_r    <= st_nxt;
         // Holds at the detect length so a shorted sink can wait without wrapping
         swc_r   <= (st_r != ST_DETECT) ? '0 :
                    ((sw_tick_r && !detect_done) ? swc_r + 1'b1 : swc_r);
         dimlo_r <= (dim_hi || dim_rise) ? '0 :
                    ((sw_tick_r && !lowpwr_hit) ? dimlo_r + 1'b1 : dimlo_r);  // [R11]
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Before ST_LOWPWR, dimming low only gates the power stage; the state is kept, so the
   // next rising edge restores current without a new soft start
   wire active  = supply_on(st_r);
   wire lit     = leds_allowed(st_r) && dim_hi;                               // [R13] [R14]
   wire sw_go   = lit && !pause_r;                                            // [R8]
   wire [1:0] lvl_nxt = !lit ? ISINK_OFF : (at_full(st_r) ? ISINK_FULL : ISINK_SS); // [R1] [R2] [R13]

   // Registered outputs, one mclk after the synchronised pin: far inside 500 ns [R15]
   // Compensation resets floated, since the loop must not integrate before start-up
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sw_clk_en       <= 1'b0;
         sw_pulse        <= 1'b0;
         ilim_full       <= 1'b0;
         sink_level      <= ISINK_OFF;
         disconnect_on   <= 1'b0;
         comp_float      <= 1'b1;
         low_power       <= 1'b0;
         ext_sync_active <= 1'b0;
      end else begin
         sw_clk_en       <= sw_go;                                            // [R9] [R14]
         sw_pulse        <= sw_go & (ext_r ? ext_tick_r : sw_tick_r);         // [R6]
         ilim_full       <= at_full(st_r);                                    // [R1] [R2]
         sink_level      <= lvl_nxt;                                          // [R15]
         disconnect_on   <= active;                                           // [R9]
         comp_float      <= !lit;                                             // [R14]
         low_power       <= (st_r == ST_LOWPWR);                              // [R11]
         ext_sync_active <= ext_r;
      end
   end
endmodule : boost_sync_and_dimming_control
`default_nettype wire

// *** common/boost_ctrl_pkg.sv ***
// Shared constants and types for the boost sync and dimming control block
package boost_ctrl_pkg;
   // Core clock
   localparam int  MCLK_MHZ           = 250;
   // Resistor-set oscillator range and fault clamp, in kHz
   localparam int  FSW_MIN_KHZ        = 200;
   localparam int  FSW_MAX_KHZ        = 2300;
   localparam int  FSW_CLAMP_KHZ      = 3500;
   // Shortest legal switching period in mclk cycles (clamp at 3.5 MHz, rounded up)
   localparam int  CLAMP_PER_CYC      = (MCLK_MHZ * 1000 + FSW_CLAMP_KHZ - 1) / FSW_CLAMP_KHZ;
   // Longest resistor-set period in mclk cycles (200 kHz, rounded down)
   localparam int  RSET_MAX_PER_CYC   = (MCLK_MHZ * 1000) / FSW_MIN_KHZ;
   // Sync-low timeout, ns and mclk cycles (rounded down)
   localparam int  SYNC_LOW_NS        = 7000;
   localparam int  SYNC_LOW_CYC       = (SYNC_LOW_NS * MCLK_MHZ) / 1000;
   // Sync-high timeout for loss detection (same 7 us figure)
   localparam int  SYNC_LOSS_CYC      = SYNC_LOW_CYC;
   // Switching-cycle counts
   localparam int  LOWPWR_SW_CYC      = 32750;
   localparam int  DETECT_MIN_SW_CYC  = 3000;
   localparam int  DETECT_MAX_SW_CYC  = 4000;
   // Counter widths
   localparam int  TMR_W              = 12;
   localparam int  SWC_W              = 16;
   localparam int  PER_W              = 11;
   // Sink current levels
   localparam logic [1:0] ISINK_OFF   = 2'h0;
   localparam logic [1:0] ISINK_SS    = 2'h1;
   localparam logic [1:0] ISINK_FULL  = 2'h2;

   typedef enum logic [2:0] {
      ST_WAIT_PIN,
      ST_DETECT,
      ST_SOFT,
      ST_RUN,
      ST_STUCK,
      ST_LOWPWR
   } seq_state_e;
endpackage : boost_ctrl_pkg

// *** rtl/sync_edge_detect.sv ***
// Link-clock sync pin front end: toggles an event flag on each sync rising edge
`timescale 1ns/10ps
`default_nettype none
module sync_edge_detect (
   input  wire logic sync_clk,
   input  wire logic rstn,
   output logic      edge_tgl
);
   // Sync pin acts as its own clock; each rising edge flips the toggle.
   // The main domain sees the toggle through a two-stage synchroniser.
   always_ff @(posedge sync_clk or negedge rstn) begin
      if (!rstn) begin
         edge_tgl <= 1'b0;
      end else begin
         edge_tgl <= ~edge_tgl;
      end
   end
endmodule : sync_edge_detect
`default_nettype wire

// *** verif/sync_dim_monitor.sv ***
// Port checker for the boost sync and dimming sequencer
`timescale 1ns/10ps
`default_nettype none
module sync_dim_monitor (
   input wire logic                             mclk,
   input wire logic                             rstn,
   input wire logic                             sync_clk,
   input wire logic                             freq_set_sync_pin,
   input wire logic                             dim_en_pin,
   input wire logic                             sink_ok,
   input wire logic                             sink_short,
   input wire logic [boost_ctrl_pkg::PER_W-1:0] rset_period,
   input wire logic                             sw_clk_en,
   input wire logic                             sw_pulse,
   input wire logic                             ilim_full,
   input wire logic [1:0]                       sink_level,
   input wire logic                             disconnect_on,
   input wire logic                             comp_float,
   input wire logic                             low_power,
   input wire logic                             ext_sync_active
);
   import boost_ctrl_pkg::*;
   // ************
   // Helper counters
   // ************
   logic [7:0]  since_r;
   logic [11:0] low_r;
   // Cycles since last pulse and pin-low run; saturate so long idles never wrap
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         since_r <= 8'hFF;
         low_r   <= 12'h000;
      end else begin
         since_r <= sw_pulse ? 8'h00 : (since_r == 8'hFF ? since_r : since_r + 8'h01);
         low_r   <= freq_set_sync_pin ? 12'h000 : (low_r == 12'hFFF ? low_r : low_r + 12'h001);
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_ss_limit: assert property (sink_level == ISINK_SS |-> !ilim_full)
      else $error("soft start with full limit");
   a_full_limit: assert property (sink_level == ISINK_FULL |-> ilim_full)
      else $error("full current with reduced limit");
   a_rate_clamp: assert property (sw_pulse |-> since_r >= 8'(CLAMP_PER_CYC - 1))
      else $error("switching pulses too close");
   a_stuck_off: assert property (low_r >= 12'h6EA |-> !sw_clk_en && !disconnect_on && sink_level == ISINK_OFF)
      else $error("not shut down on stuck-low pin");
   a_sync_fallback: assert property ($fell(ext_sync_active) && dim_en_pin && freq_set_sync_pin |-> ##[0:8] sw_clk_en)
      else $error("no resume after sync loss");
   a_dim_off: assert property ($fell(dim_en_pin) |-> ##[1:4] (sink_level == ISINK_OFF && !sw_clk_en && comp_float))
      else $error("dim low did not turn off");
   a_on_needs_dim: assert property (sink_level != ISINK_OFF |-> $past(dim_en_pin, 3) || $past(dim_en_pin, 4))
      else $error("sinks on without dim high");
   a_lowpwr_off: assert property (low_power |-> sink_level == ISINK_OFF && !sw_clk_en)
      else $error("active in low power");
endmodule : sync_dim_monitor
`default_nettype wire

// *** verif/host_model.sv ***
// Host model driving the sync pin as a level or as a sync clock
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic sync_on,
   input  wire logic pin_hi,
   output logic      sync_clk,
   output logic      freq_set_sync_pin
);
   // Pulses 150 ns high and low; the clock stands still outside bursts
   initial sync_clk = 1'b0;
   always begin
      #150;
      sync_clk = sync_on ? ~sync_clk : 1'b0;
   end
   // Pin follows the clock, else floats high or is held low
   assign freq_set_sync_pin = sync_on ? sync_clk : pin_hi;
endmodule : host_model
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the boost sync and dimming sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
   import boost_ctrl_pkg::*;
   logic       mclk, rstn, sync_clk, freq_set_sync_pin, dim_en_pin, sink_ok, sync_on, pin_hi;
   logic       sw_clk_en, sw_pulse, ilim_full, disconnect_on, comp_float, low_power, ext_sync_active;
   logic [1:0] sink_level;
   int         err_count, n_tests, i, n;
   host_model host (.sync_on(sync_on), .pin_hi(pin_hi), .sync_clk(sync_clk), .freq_set_sync_pin(freq_set_sync_pin));
   boost_sync_and_dimming_control dut (.mclk(mclk), .rstn(rstn), .sync_clk(sync_clk),
      .freq_set_sync_pin(freq_set_sync_pin), .dim_en_pin(dim_en_pin), .sink_ok(sink_ok), .sink_short(1'b0),
      .rset_period(PER_W'(72)), .sw_clk_en(sw_clk_en), .sw_pulse(sw_pulse), .ilim_full(ilim_full),
      .sink_level(sink_level), .disconnect_on(disconnect_on), .comp_float(comp_float), .low_power(low_power),
      .ext_sync_active(ext_sync_active));
   // ************
   // Helpers
   // ************
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   task automatic tick(input int c);
      repeat (c) @(negedge mclk);
   endtask : tick
   // Bounded wait for the sync-select flag; a spent bound ends the run
   task automatic wait_ext(input logic v);
      for (i = 0; i < 2100 && ext_sync_active !== v; i++) tick(1);
      if (i >= 2100) begin
         err_count++;
         $display("mismatch at %0t: sync select wait ran out", $time);
         tally_and_finish;
      end
   endtask : wait_ext
   task automatic count_pulses(input int len);
      n = 0;
      repeat (len) begin
         tick(1);
         n += (sw_pulse === 1'b1);
      end
   endtask : count_pulses
   // ************
   // Scenarios
   // ************
   task automatic t_power_up;
      chk(comp_float, 1'b1);
      dim_en_pin = 1'b1;
      tick(2500);
      chk(disconnect_on, 1'b0);
      pin_hi = 1'b1;
      tick(20);
      chk(disconnect_on, 1'b1);
   endtask : t_power_up
   task automatic t_stuck;
      pin_hi = 1'b0;
      tick(1800);
      chk(disconnect_on, 1'b0);
      chk(sink_level, ISINK_OFF);
      pin_hi = 1'b1;
      tick(20);
      chk(sink_level, ISINK_SS);
      chk(ilim_full, 1'b0);
   endtask : t_stuck
   task automatic t_run;
      sink_ok = 1'b1;
      tick(10);
      chk(sink_level, ISINK_FULL);
      chk(ilim_full, 1'b1);
      count_pulses(720);
      chk(16'(n), 16'h000A);
   endtask : t_run
   task automatic t_dim;
      dim_en_pin = 1'b0;
      tick(5);
      chk({sink_level, sw_clk_en, comp_float}, {ISINK_OFF, 2'b01});
      dim_en_pin = 1'b1;
      tick(5);
      chk({sink_level, sw_clk_en, comp_float}, {ISINK_FULL, 2'b10});
   endtask : t_dim
   task automatic t_sync;
      tick(200);
      sync_on = 1'b1;
      wait_ext(1'b1);
      count_pulses(750);
      chk(16'(n), 16'h000A);
      chk(sink_level, ISINK_FULL);
      sync_on = 1'b0;
      wait_ext(1'b0);
      tick(10);
      chk(sw_clk_en, 1'b1);
      count_pulses(720);
      chk(16'(n), 16'h000A);
   endtask : t_sync
   initial begin
      rstn = 1'b0;
      dim_en_pin = 1'b0;
      sink_ok = 1'b0;
      sync_on = 1'b0;
      pin_hi = 1'b0;
      err_count = 0;
      n_tests = 0;
      tick(10);
      rstn = 1'b1;
      tick(2);
      t_power_up;
      t_stuck;
      t_run;
      t_dim;
      t_sync;
      tally_and_finish;
   end
endmodule : tb
bind boost_sync_and_dimming_control sync_dim_monitor u_mon (.mclk(mclk), .rstn(rstn), .sync_clk(sync_clk),
   .freq_set_sync_pin(freq_set_sync_pin), .dim_en_pin(dim_en_pin), .sink_ok(sink_ok), .sink_short(sink_short),
   .rset_period(rset_period), .sw_clk_en(sw_clk_en), .sw_pulse(sw_pulse), .ilim_full(ilim_full),
   .sink_level(sink_level), .disconnect_on(disconnect_on), .comp_float(comp_float), .low_power(low_power),
   .ext_sync_active(ext_sync_active));
`default_nettype wire
